// file: inc/ovrdet_pkg.sv
// Constants shared by the over-range detector design files
package ovrdet_pkg;
    // Channel and datapath sizes
    localparam int CH_N        = 4;   // Converter channels
    localparam int SAMPLE_W    = 12;  // Two's complement sample width
    localparam int LEVEL_W     = 8;   // Threshold field width, fraction of 256
    localparam int EXP_W       = 3;   // Stretch exponent width
    localparam int HOLD_W      = 10;  // Holds the longest stretch, 4 * 2^7
    localparam int LEVEL_SHIFT = SAMPLE_W - 1 - LEVEL_W; // Threshold to sample scale

    // Bus sizes
    localparam int ADDR_W = 12;
    localparam int IDX_W  = ADDR_W - 2;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LEVEL      = 10'h211;
    localparam logic [IDX_W-1:0] IDX_CONFIG     = 10'h213;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h214;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h215;

    // Reset values
    localparam logic [7:0]      LEVEL_RESET  = 8'hf2;
    localparam logic [7:0]      CONFIG_RESET = 8'h07;
    localparam logic [CH_N-1:0] MASK_RESET   = 4'h0;

    // Config field positions
    localparam int ENABLE_BIT = 3;
    localparam int EXP_LSB    = 0;

    // Stretch base length in sampling cycles
    localparam logic [HOLD_W-1:0] HOLD_BASE = 10'h004;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: inc/ovrdet_chan_if.sv
// Signals between the register side and one channel detector
`timescale 1ns/10ps
interface ovrdet_chan_if;
    logic [ovrdet_pkg::SAMPLE_W-1:0] sample;   // Current sample, two's complement
    logic [ovrdet_pkg::LEVEL_W-1:0]  level;    // Detection threshold
    logic [ovrdet_pkg::EXP_W-1:0]    exponent; // Stretch exponent
    logic                            enable;   // Global alarm enable
    logic                            flag;     // Stretched over-range output
    logic                            hit;      // Detection in this cycle

    // Register side drives settings and samples
    modport top (
        output sample,
        output level,
        output exponent,
        output enable,
        input  flag,
        input  hit
    );

    // Channel side answers with flag and hit
    modport chan (
        input  sample,
        input  level,
        input  exponent,
        input  enable,
        output flag,
        output hit
    );
endinterface

// file: rtl/ovrdet_chan.sv
// One channel: magnitude compare and pulse stretcher
`timescale 1ns/10ps
module ovrdet_chan (
    // Clock and reset
    input wire logic     aclk,
    input wire logic     aresetn,
    // Settings in, flag out
    ovrdet_chan_if.chan  port
);
    logic [ovrdet_pkg::SAMPLE_W-1:0] mag;      // Absolute sample value
    logic [ovrdet_pkg::SAMPLE_W-1:0] limit;    // Threshold at sample scale
    logic [ovrdet_pkg::HOLD_W-1:0]   hold_len; // Stretch length in cycles
    logic [ovrdet_pkg::HOLD_W-1:0]   hold_cnt; // Cycles left after this one
    logic                            flag;     // Registered output

    ////////////////////////////////////////////////////////////////////////////
    // Detection

    // Most negative code maps to 2^(W-1), still fits unsigned
    always_comb begin
        if (port.sample[ovrdet_pkg::SAMPLE_W-1]) begin
            mag = ~port.sample + 1'b1;
        end else begin
            mag = port.sample;
        end
    end

    // Threshold is a fraction of 256 full-scale units
    assign limit = {1'b0, port.level, {ovrdet_pkg::LEVEL_SHIFT{1'b0}}}; // [R2]

    // Level reached counts as over range; gated by enable
    assign port.hit = port.enable && (mag >= limit); // [R1] [R3]

    ////////////////////////////////////////////////////////////////////////////
    // Stretcher

    // Each exponent step doubles the hold
    assign hold_len = ovrdet_pkg::HOLD_BASE << port.exponent; // [R4]

    // Hit reloads the counter, so a run of hits extends the pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag     <= 1'b0;
            hold_cnt <= '0;
        end else if (!port.enable) begin
            flag     <= 1'b0; // [R3]
            hold_cnt <= '0;
        end else if (port.hit) begin
            flag     <= 1'b1; // [R1]
            hold_cnt <= hold_len - 1'b1; // [R4] [R6]
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1; // [R4]
        end else begin
            flag     <= 1'b0; // [R6]
        end
    end

    assign port.flag = flag;
endmodule

// file: rtl/ovrdet_top.sv
// Four-channel over-range detector with AXI4-Lite registers
// What this block does
// [R1] Flag channel when sample magnitude reaches threshold
// [R2] Threshold is fraction of 256, reset 0xf2
// [R3] Enable bit 3 low holds all flags low
// [R4] Flag lasts at least 4 times 2^N cycles
// [R5] Software writes zero to config bits 7:4
// [R6] New detection restarts the hold period
`timescale 1ns/10ps
module ovrdet_top #(
    parameter int CH_N = ovrdet_pkg::CH_N // Channel count, four pins below
) (
    // Clock and reset
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    // AXI4-Lite write address
    input  wire logic [ovrdet_pkg::ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output wire logic                               s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output wire logic                               s_axi_wready,
    // AXI4-Lite write response
    output wire logic [1:0]                         s_axi_bresp,
    output wire logic                               s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ovrdet_pkg::ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output wire logic                               s_axi_arready,
    // AXI4-Lite read data
    output wire logic [31:0]                        s_axi_rdata,
    output wire logic [1:0]                         s_axi_rresp,
    output wire logic                               s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    // Samples, one per sampling cycle
    input  wire logic [ovrdet_pkg::SAMPLE_W-1:0]    sample_a,
    input  wire logic [ovrdet_pkg::SAMPLE_W-1:0]    sample_b,
    input  wire logic [ovrdet_pkg::SAMPLE_W-1:0]    sample_c,
    input  wire logic [ovrdet_pkg::SAMPLE_W-1:0]    sample_d,
    // Over-range pins
    output wire logic                               overrange_flag_a,
    output wire logic                               overrange_flag_b,
    output wire logic                               overrange_flag_c,
    output wire logic                               overrange_flag_d,
    // Interrupt
    output wire logic                               irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0]      range_limit_level;  // Threshold register
    logic [7:0]      range_alarm_config; // Enable and exponent register
    logic [CH_N-1:0] irq_status;         // Sticky detection bits
    logic [CH_N-1:0] irq_mask;           // Interrupt enables
    logic                               range_alarm_enable;
    logic [ovrdet_pkg::EXP_W-1:0]       pulse_stretch_exponent;

    assign range_alarm_enable     = range_alarm_config[ovrdet_pkg::ENABLE_BIT];
    assign pulse_stretch_exponent =
        range_alarm_config[ovrdet_pkg::EXP_LSB +: ovrdet_pkg::EXP_W];

    ////////////////////////////////////////////////////////////////////////////
    // Write channel

    logic                            aw_held;  // Write address captured
    logic                            w_held;   // Write data captured
    logic [ovrdet_pkg::IDX_W-1:0]    aw_idx;   // Captured word index
    logic [31:0]                     w_data;   // Captured data
    logic [3:0]                      w_strb;   // Captured strobes
    logic                            bvalid;   // Response pending
    logic [1:0]                      bresp;    // Response code
    logic                            do_write; // Both halves present
    logic                            w_hit;    // Index is mapped

    // Accept each half once; hold off until the response is taken
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready  = !w_held && !bvalid;
    assign do_write      = aw_held && w_held && !bvalid;
    assign w_hit = (aw_idx == ovrdet_pkg::IDX_LEVEL) || (aw_idx == ovrdet_pkg::IDX_CONFIG) ||
                   (aw_idx == ovrdet_pkg::IDX_IRQ_STATUS) || (aw_idx == ovrdet_pkg::IDX_IRQ_MASK);

    // Address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[ovrdet_pkg::ADDR_W-1:2];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Response; unmapped addresses answer with slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= ovrdet_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= w_hit ? ovrdet_pkg::RESP_OKAY : ovrdet_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;

    logic wr_lane0; // Low byte lane written
    assign wr_lane0 = do_write && w_strb[0];

    // Threshold register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            range_limit_level <= ovrdet_pkg::LEVEL_RESET; // [R2]
        end else if (wr_lane0 && aw_idx == ovrdet_pkg::IDX_LEVEL) begin
            range_limit_level <= w_data[7:0];
        end
    end

    // Config register; upper bits stored as written, left zero by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            range_alarm_config <= ovrdet_pkg::CONFIG_RESET; // [R3] [R4]
        end else if (wr_lane0 && aw_idx == ovrdet_pkg::IDX_CONFIG) begin
            range_alarm_config <= w_data[7:0]; // [R5]
        end
    end

    // Interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= ovrdet_pkg::MASK_RESET;
        end else if (wr_lane0 && aw_idx == ovrdet_pkg::IDX_IRQ_MASK) begin
            irq_mask <= w_data[CH_N-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels

    logic [ovrdet_pkg::SAMPLE_W-1:0] samples [CH_N]; // Sample per channel
    logic [CH_N-1:0]                 flags;          // Stretched outputs
    logic [CH_N-1:0]                 hits;           // Detections this cycle

    assign samples[0] = sample_a;
    assign samples[1] = sample_b;
    assign samples[2] = sample_c;
    assign samples[3] = sample_d;

    ovrdet_chan_if ch_if[CH_N] ();

    // One detector per channel, all sharing the same settings
    genvar gi;
    generate
        for (gi = 0; gi < CH_N; gi++) begin : g_chan
            assign ch_if[gi].sample   = samples[gi];
            assign ch_if[gi].level    = range_limit_level;
            assign ch_if[gi].exponent = pulse_stretch_exponent;
            assign ch_if[gi].enable   = range_alarm_enable;
            assign flags[gi]          = ch_if[gi].flag;
            assign hits[gi]           = ch_if[gi].hit;
            ovrdet_chan i_ovrdet_chan (
                .aclk    (aclk),
                .aresetn (aresetn),
                .port    (ch_if[gi])
            );
        end
    endgenerate

    assign overrange_flag_a = flags[0];
    assign overrange_flag_b = flags[1];
    assign overrange_flag_c = flags[2];
    assign overrange_flag_d = flags[3];

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt

    // Write one to clear; a detection in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
        end else if (wr_lane0 && aw_idx == ovrdet_pkg::IDX_IRQ_STATUS) begin
            irq_status <= (irq_status & ~w_data[CH_N-1:0]) | hits;
        end else begin
            irq_status <= irq_status | hits;
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    logic                         rvalid; // Read data pending
    logic [31:0]                  rdata;  // Registered read data
    logic [1:0]                   rresp;  // Read response code
    logic [ovrdet_pkg::IDX_W-1:0] ar_idx; // Requested word index

    assign s_axi_arready = !rvalid;
    assign ar_idx        = s_axi_araddr[ovrdet_pkg::ADDR_W-1:2];

    // One read at a time; data registered on acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= ovrdet_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid <= 1'b1;
            rresp  <= ovrdet_pkg::RESP_OKAY;
            case (ar_idx)
                ovrdet_pkg::IDX_LEVEL: begin
                    rdata <= {24'h000000, range_limit_level};
                end
                ovrdet_pkg::IDX_CONFIG: begin
                    rdata <= {24'h000000, range_alarm_config};
                end
                ovrdet_pkg::IDX_IRQ_STATUS: begin
                    rdata <= {28'h0000000, irq_status};
                end
                ovrdet_pkg::IDX_IRQ_MASK: begin
                    rdata <= {28'h0000000, irq_mask};
                end
                default: begin
                    rdata <= '0; // Unmapped reads zero with error
                    rresp <= ovrdet_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata  = rdata;
    assign s_axi_rresp  = rresp;
endmodule

// file: dv/ovrdet_checker.sv
// Checker for the over-range detector top-level ports
`timescale 1ns/10ps
module ovrdet_checker #(
    parameter int CH_N = 4 // Channel count of the top
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register writes
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    // Channel a sample and all pins
    input wire logic [11:0] sample_a,
    input wire logic        overrange_flag_a,
    input wire logic        overrange_flag_b,
    input wire logic        overrange_flag_c,
    input wire logic        overrange_flag_d
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  lvl;   // Shadow threshold
    logic [7:0]  cfg;   // Shadow config
    logic        pend;  // Write taken last edge
    logic [9:0]  pidx;  // Its word index
    logic [7:0]  pdat;  // Its low byte
    logic [9:0]  since; // Position inside the stretch of a
    logic [11:0] mag;   // Magnitude of sample a
    logic [9:0]  hold;  // Stretch length
    logic        en;    // Alarm enable
    logic        hit;   // Detection on a
    // Mirror writes; they land one edge after both channels are taken
    always_ff @(posedge aclk) begin
        pidx <= s_axi_awaddr[11:2];
        pdat <= s_axi_wdata[7:0];
        if (!aresetn) begin
            lvl  <= ovrdet_pkg::LEVEL_RESET;
            cfg  <= ovrdet_pkg::CONFIG_RESET;
            pend <= 1'b0;
        end else begin
            pend <= s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                    && s_axi_wstrb[0];
            if (pend && pidx == ovrdet_pkg::IDX_LEVEL) lvl <= pdat;
            if (pend && pidx == ovrdet_pkg::IDX_CONFIG) cfg <= pdat;
        end
    end
    assign en   = cfg[ovrdet_pkg::ENABLE_BIT];
    assign hold = 10'h004 << cfg[2:0];
    assign mag  = sample_a[11] ? 12'(-sample_a) : sample_a;
    assign hit  = en && (mag >= {1'b0, lvl, 3'h0});
    // Zero means idle; cleared at expiry so a later exponent change cannot confuse it
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) since <= 10'h000;
        else if (hit) since <= 10'h001;
        else if (since == hold) since <= 10'h000;
        else if (since != 10'h000) since <= since + 10'h001;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_flag_two;
        overrange_flag_a ##1 overrange_flag_a;
    endsequence
    a_hit_raises_flag: assert property (hit |=> s_flag_two)
        else $error("flag a did not follow a hit");
    a_rise_needs_hit: assert property ($rose(overrange_flag_a) |-> $past(hit))
        else $error("flag a rose without a scaled detection");
    a_disabled_all_low: assert property (!en |=> !(overrange_flag_a || overrange_flag_b
        || overrange_flag_c || overrange_flag_d))
        else $error("flag high while disabled");
    a_stretch_exact: assert property (en |-> overrange_flag_a == (since != 10'h000))
        else $error("flag a length differs from the stretch");
    a_restart_hold: assert property (hit && overrange_flag_a |=> overrange_flag_a [*4])
        else $error("flag a fell soon after a new hit");
endmodule
bind ovrdet_top ovrdet_checker #(.CH_N(CH_N)) i_ovrdet_checker (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .sample_a(sample_a), .overrange_flag_a(overrange_flag_a),
    .overrange_flag_b(overrange_flag_b), .overrange_flag_c(overrange_flag_c),
    .overrange_flag_d(overrange_flag_d));

// file: dv/ovrdet_host_model.sv
// Host logic that watches the four over-range pins
`timescale 1ns/10ps
module ovrdet_host_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Pins from the device
    input  wire logic [3:0] flags,
    // Last pulse length and pulse count per channel
    output logic [9:0]      width [4],
    output logic [7:0]      pulses [4]
);
    ////////////////////////////////////////////////////////////////////////
    logic [9:0] run [4]; // High cycles so far
    // Latch a pulse length only at its fall, so the host sees whole pulses
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 4; i++) begin
            if (!aresetn) begin
                run[i]    <= 10'h000;
                width[i]  <= 10'h000;
                pulses[i] <= 8'h00;
            end else if (flags[i]) begin
                run[i] <= run[i] + 10'h001;
            end else if (run[i] != 10'h000) begin
                width[i]  <= run[i];
                pulses[i] <= pulses[i] + 8'h01;
                run[i]    <= 10'h000;
            end
        end
    end
endmodule

// file: dv/ovrdet_top_tb_top.sv
// Self-checking bench for the over-range detector
`timescale 1ns/10ps
module ovrdet_top_tb_top;
    ////////////////////////////////////////////////////////////////////////
    logic        aclk = 1'b0; // Sampling clock
    logic        aresetn;     // Synchronous reset
    logic [11:0] awaddr;      // Bus master side
    logic [11:0] araddr;
    logic [31:0] wdata;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic        awready;     // Slave side
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic        irq;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [11:0] samp [4];    // Channel samples
    wire  [3:0]  flags;       // Over-range pins
    logic [9:0]  width [4];   // Host view of pulses
    logic [7:0]  pulses [4];
    logic [7:0]  p0;          // Pulse count before a scenario
    int          num_errors = 0;
    int          comparisons = 0;
    always #5 aclk = ~aclk;
    ovrdet_top i_ovrdet_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sample_a(samp[0]), .sample_b(samp[1]),
        .sample_c(samp[2]), .sample_d(samp[3]), .overrange_flag_a(flags[0]),
        .overrange_flag_b(flags[1]), .overrange_flag_c(flags[2]),
        .overrange_flag_d(flags[3]), .irq(irq));
    ovrdet_host_model i_ovrdet_host_model (.aclk(aclk), .aresetn(aresetn), .flags(flags),
        .width(width), .pulses(pulses));
    ////////////////////////////////////////////////////////////////////////
    // Count and compare
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task summarize;
        $display("errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task give_up(input string what);
        num_errors++;
        $display("unexpected %s: expected an answer, seen none", what);
        summarize();
    endtask
    // Write with both channels offered together, response awaited
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        if (n >= 40) give_up("write response");
        bready <= 1'b0;
        chk("bresp", 32'(r), 32'(bresp));
    endtask
    task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        if (n >= 40) give_up("read data");
        rready <= 1'b0;
        chk("rdata", d, rdata);
        chk("rresp", 32'(r), 32'(rresp));
    endtask
    // One sampling cycle at level v on channel ch
    task hit(input int ch, input logic [11:0] v);
        @(posedge aclk);
        samp[ch] <= v;
        @(posedge aclk);
        samp[ch] <= 12'h000;
    endtask
    // Wait for the pulse to end and judge its length
    task wait_pulse(input int ch, input logic [9:0] exp);
        int n;
        n = 0;
        while (pulses[ch] == p0 && n < 700) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 700) give_up("pulse end");
        chk("pulse width", 32'(exp), 32'(width[ch]));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd(12'h844, 32'h0000_00f2, 2'h0);
        rd(12'h84c, 32'h0000_0007, 2'h0);
        rd(12'h850, 32'h0, 2'h0);
        rd(12'h000, 32'h0, 2'h2);
        wr(12'h000, 32'h1, 2'h2);
    endtask
    // Full scale on every channel while disabled
    task t_disabled;
        for (int c = 0; c < 4; c++) samp[c] <= 12'h800;
        repeat (8) @(posedge aclk);
        chk("flags", 32'h0, 32'(flags));
        for (int c = 0; c < 4; c++) samp[c] <= 12'h000;
        rd(12'h850, 32'h0, 2'h0);
    endtask
    // Threshold 0x80 is 1024 counts; both signs and the edge value
    task t_threshold;
        wr(12'h84c, 32'h08, 2'h0);
        wr(12'h844, 32'h80, 2'h0);
        p0 = pulses[0];
        hit(0, 12'h3ff);
        repeat (4) @(posedge aclk);
        chk("pulse count", 32'(p0), 32'(pulses[0]));
        for (int c = 0; c < 4; c++) begin
            p0 = pulses[c];
            hit(c, c[0] ? 12'hc00 : 12'h400);
            wait_pulse(c, 10'h004);
        end
    endtask
    task t_exponent;
        for (int n = 0; n < 8; n++) begin
            wr(12'h84c, 32'h08 | n, 2'h0);
            p0 = pulses[0];
            hit(0, 12'h800);
            wait_pulse(0, 10'(4 << n));
        end
    endtask
    // Second hit two cycles later restarts the stretch
    task t_restart;
        wr(12'h84c, 32'h08, 2'h0);
        p0 = pulses[0];
        hit(0, 12'h7ff);
        hit(0, 12'h7ff);
        wait_pulse(0, 10'h006);
    endtask
    task t_irq;
        wr(12'h850, 32'hf, 2'h0);
        rd(12'h850, 32'h0, 2'h0);
        hit(1, 12'h800);
        repeat (8) @(posedge aclk);
        rd(12'h850, 32'h2, 2'h0);
        chk("irq masked", 32'h0, 32'(irq));
        wr(12'h854, 32'h2, 2'h0);
        rd(12'h854, 32'h2, 2'h0);
        chk("irq", 32'h1, 32'(irq));
        wr(12'h850, 32'h2, 2'h0);
        chk("irq cleared", 32'h0, 32'(irq));
    endtask
    // Clearing enable in mid-pulse drops the pin
    task t_disable_mid;
        wr(12'h84c, 32'h0f, 2'h0);
        hit(2, 12'h800);
        repeat (3) @(posedge aclk);
        chk("flag c", 32'h1, 32'(flags[2]));
        wr(12'h84c, 32'h07, 2'h0);
        repeat (2) @(posedge aclk);
        chk("flag c off", 32'h0, 32'(flags[2]));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        for (int c = 0; c < 4; c++) samp[c] = 12'h000;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_disabled();
        t_threshold();
        t_exponent();
        t_restart();
        t_irq();
        t_disable_mid();
        summarize();
    end
endmodule
